// [logic/sarro_pkg.sv]
// Constants and types for the serial-readout converter control block
package sarro_pkg;

    // Result word
    localparam int RES_W   = 18;
    localparam int SHIFT_W = RES_W + 1;
    localparam logic [RES_W-1:0] SIGN_BIT   = 18'h20000;
    localparam logic [RES_W-1:0] RESULT_RST = 18'h00000;
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 19'h00000;

    // Value of the indicator bit sent ahead of the result
    localparam logic BUSY_BIT_VAL = 1'b0;

    // Conversion timing on the internal clock
    localparam int CLK_MHZ    = 200;
    localparam int CONV_NS    = 500;
    localparam int CONV_CYC   = (CONV_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_CNT_W = $clog2(CONV_CYC + 1);
    localparam logic [CONV_CNT_W-1:0] CONV_LAST =
        CONV_CNT_W'(CONV_CYC - 1);
    localparam logic [CONV_CNT_W-1:0] CONV_CNT_RST = '0;

    // Serial clock edge counter, gray coded across domains
    localparam int GRAY_W = 4;
    localparam logic [GRAY_W-1:0] GRAY_RST = 4'h0;

    typedef enum logic {
        SARRO_ST_ACQ,
        SARRO_ST_CONV
    } sarro_state_t;

    typedef enum logic {
        SARRO_MODE_DAISY,
        SARRO_MODE_CS
    } sarro_mode_t;

    typedef struct packed {
        logic [RES_W-1:0] positive_analog_input;
        logic [RES_W-1:0] negative_analog_input;
    } sarro_sample_t;

endpackage

// [logic/sarro_core.sv]
// Conversion control and serial readout of the differential converter
//
// Notes on behaviour
// - Three-wire: start pin doubles as chip select.
// - Serial input level at start picks style.
// - Four-wire, chip-select style: serial input acts as chip select.
// - Result shifts out on host serial clock.
// - Start captures differential input into array.
// - Inputs disconnected while conversion runs.
// - Conversion timed by internal clock only.
// - Conversion end reconnects inputs, begins acquisition.
// - Powered down in acquisition, result still readable.
// - Serial input low means daisy, high chip-select.
// - Start rising edge: output high-Z, sample, convert.
// - Busy option sends one leading indicator bit.
// - Result coded in two's complement.
`timescale 1ns/1ps
module sarro_core
    import sarro_pkg::*;
(
    // Clock, reset, enable
    input  wire logic          i_clk,
    input  wire logic          i_resetn,
    input  wire logic          i_ce,
    // Serial link
    input  wire logic          i_sclk,
    input  wire logic          i_conversion_start_pin,
    input  wire logic          i_serial_in,
    output logic               o_serial_out,
    output logic               o_serial_out_oe_n,
    // Static options
    input  wire logic          i_busy_indicator_en,
    input  wire logic          i_four_wire,
    // Analog front end model
    input  wire sarro_sample_t i_analog,
    output logic               o_sample_connect,
    output logic               o_power_down
);

    // Link domain: free count of falling serial clock edges
    logic [GRAY_W-1:0] sclk_bin;
    logic [GRAY_W-1:0] sclk_gray;
    logic              lrst_s1;
    logic              lrst_s2;
    wire  [GRAY_W-1:0] next_sclk_bin  = sclk_bin + GRAY_W'(1);
    wire  [GRAY_W-1:0] next_sclk_gray = next_sclk_bin ^ (next_sclk_bin >> 1);

    always_ff @(negedge i_sclk)
    begin
        lrst_s1 <= i_resetn;
        lrst_s2 <= lrst_s1;
    end

    // Only the count crosses, gray coded; data stays in the core domain
    always_ff @(negedge i_sclk)
    begin
        if (!lrst_s2)
        begin
            sclk_bin  <= GRAY_RST;
            sclk_gray <= GRAY_RST;
        end
        else
        begin
            sclk_bin  <= next_sclk_bin;
            sclk_gray <= next_sclk_gray;
        end
    end

    // Core domain synchronisers
    logic              conv_s1;
    logic              conv_s2;
    logic              conv_d;
    logic              din_s1;
    logic              din_s2;
    logic [GRAY_W-1:0] gray_s1;
    logic [GRAY_W-1:0] gray_s2;
    logic [GRAY_W-1:0] gray_d;
    logic              cs_d;
    logic              cs_act;

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            // Pins idle high; a low reset value would fake a start edge
            conv_s1 <= 1'b1;
            conv_s2 <= 1'b1;
            conv_d  <= 1'b1;
            din_s1  <= 1'b1;
            din_s2  <= 1'b1;
            gray_s1 <= GRAY_RST;
            gray_s2 <= GRAY_RST;
            gray_d  <= GRAY_RST;
            cs_d    <= 1'b0;
        end
        else if (i_ce)
        begin
            conv_s1 <= i_conversion_start_pin;
            conv_s2 <= conv_s1;
            conv_d  <= conv_s2;
            din_s1  <= i_serial_in;
            din_s2  <= din_s1;
            gray_s1 <= sclk_gray;
            gray_s2 <= gray_s1;
            gray_d  <= gray_s2;
            cs_d    <= cs_act;
        end
    end

    // State
    sarro_state_t            state;
    sarro_mode_t             mode;
    sarro_sample_t           held;
    logic [CONV_CNT_W-1:0]   conv_cnt;
    logic [RES_W-1:0]        sar_acc;
    logic [RES_W-1:0]        sar_mask;
    logic [RES_W-1:0]        result;
    logic [SHIFT_W-1:0]      shreg;

    // Decode
    wire st_acq    = (state == SARRO_ST_ACQ);
    wire st_conv   = (state == SARRO_ST_CONV);
    wire conv_rise = conv_s2 & ~conv_d;
    wire sclk_step = (gray_s2 != gray_d);
    wire conv_done = st_conv && (conv_cnt == CONV_LAST);
    wire start     = conv_rise && st_acq;
    // Four-wire in chip-select style reads the serial input as select, else the start pin
    assign cs_act  = (mode == SARRO_MODE_CS && i_four_wire) ?
                     ~din_s2 : ~conv_s2;
    wire cs_fall   = cs_act & ~cs_d;
    wire load      = (cs_fall && st_acq) || (conv_done && cs_act);
    wire shift     = sclk_step && cs_act && st_acq && !load;
    wire drive     = st_acq && cs_act && !conv_rise;

    // Successive approximation on the held pair
    wire [RES_W:0]   diff   = {1'b0, held.positive_analog_input} -
                              {1'b0, held.negative_analog_input};
    wire [RES_W-1:0] half   = diff[RES_W:1];
    wire [RES_W-1:0] target = half ^ SIGN_BIT;
    wire [RES_W-1:0] trial  = sar_acc | sar_mask;
    wire             keep   = (trial <= target);
    // A load at conversion end must not see the previous result
    wire [RES_W-1:0]   fresh     = conv_done ? (sar_acc ^ SIGN_BIT) : result;
    wire [SHIFT_W-1:0] load_word = i_busy_indicator_en ?
                                   {BUSY_BIT_VAL, fresh} :
                                   {fresh, 1'b0};
    wire shift_in = (mode == SARRO_MODE_DAISY) ? din_s2 : 1'b0;

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            state    <= SARRO_ST_ACQ;
            mode     <= SARRO_MODE_CS;
            conv_cnt <= CONV_CNT_RST;
        end
        else if (i_ce)
        begin
            if (start)
            begin
                state    <= SARRO_ST_CONV;
                mode     <= din_s2 ? SARRO_MODE_CS
                                   : SARRO_MODE_DAISY;
                conv_cnt <= CONV_CNT_RST;
            end
            else if (conv_done)
                state    <= SARRO_ST_ACQ;
            else if (st_conv)
                conv_cnt <= conv_cnt + CONV_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            held     <= '0;
            sar_acc  <= RESULT_RST;
            sar_mask <= RESULT_RST;
            result   <= RESULT_RST;
        end
        else if (i_ce)
        begin
            if (start)
            begin
                held     <= i_analog;
                sar_acc  <= RESULT_RST;
                sar_mask <= SIGN_BIT;
            end
            else if (st_conv && sar_mask != RESULT_RST)
            begin
                sar_acc  <= keep ? trial : sar_acc;
                sar_mask <= sar_mask >> 1;
            end
            if (conv_done)
                result <= sar_acc ^ SIGN_BIT;
        end
    end

    // Readout shifts only in acquisition, while the core sleeps
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            shreg             <= SHIFT_RST;
            o_serial_out_oe_n <= 1'b1;
            o_sample_connect  <= 1'b1;
            o_power_down      <= 1'b1;
        end
        else if (i_ce)
        begin
            if (load)
                shreg <= load_word;
            else if (shift)
                shreg <= {shreg[SHIFT_W-2:0], shift_in};
            o_serial_out_oe_n <= ~drive;
            o_sample_connect  <= (st_acq && !conv_rise) || conv_done;
            o_power_down      <= (st_acq && !conv_rise) || conv_done;
        end
    end

    assign o_serial_out = shreg[SHIFT_W-1];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_start;
        start && i_ce;
    endsequence

    sequence s_done;
        conv_done && i_ce;
    endsequence

    chk_start_hiz: assert property (
        s_start |=> o_serial_out_oe_n && !o_sample_connect)
        else $error("output not released at conversion start");

    chk_mode_latch: assert property (
        s_start |=> mode == ($past(din_s2) ? SARRO_MODE_CS
                                           : SARRO_MODE_DAISY))
        else $error("style not taken from serial input");

    chk_input_capture: assert property (
        s_start |=> held == $past(i_analog))
        else $error("input not captured at start");

    chk_conv_isolated: assert property (
        st_conv && i_ce |=> !o_sample_connect || $past(conv_done))
        else $error("inputs connected during conversion");

    chk_conv_length: assert property (
        st_conv |-> conv_cnt <= CONV_LAST)
        else $error("conversion overran its cycle count");

    chk_reconnect_sleep: assert property (
        s_done |=> st_acq && o_sample_connect && o_power_down)
        else $error("no acquisition after conversion");

    chk_result_code: assert property (
        s_done |=> result == $past(half))
        else $error("result not two's complement of difference");

    chk_shift_msb: assert property (
        shift && i_ce |=> o_serial_out == $past(shreg[SHIFT_W-2]))
        else $error("serial output did not advance one bit");

    chk_busy_lead: assert property (
        load && i_ce && i_busy_indicator_en |=>
        o_serial_out == BUSY_BIT_VAL)
        else $error("indicator bit missing");

    chk_select_pins: assert property (
        i_ce && (mode == SARRO_MODE_CS) &&
        (i_four_wire ? din_s2 : conv_s2) |=> o_serial_out_oe_n)
        else $error("output driven while deselected");

endmodule

// [tb/sarro_host.sv]
// Host controller model: start pin, serial input and serial clock
`timescale 1ns/1ps
module sarro_host (
    // Clock for pin changes
    input  wire logic i_clk,
    // From device
    input  wire logic i_serial_out,
    input  wire logic i_serial_out_oe_n,
    // To device
    output logic      o_sclk,
    output logic      o_start,
    output logic      o_serial_in
);
    initial
    begin
        o_sclk      = 1'b0;
        o_start     = 1'b1;
        o_serial_in = 1'b1;
    end

    // Style level held stable across the start edge
    task automatic set(input logic st, input logic si);
        @(negedge i_clk);
        o_start     = st;
        o_serial_in = si;
    endtask

    // Clock only stands still low outside frames
    task automatic pulse(input int n);
        repeat (n)
        begin
            #80 o_sclk = 1'b1;
            #80 o_sclk = 1'b0;
        end
    endtask

    // Sample on rise, device advances on fall; released line reads inverted
    task automatic xfer(input int n, input bit chain, input logic [19:0] din,
                        output logic [19:0] q);
        q = 20'h00000;
        for (int i = 0; i < n; i++)
        begin
            #80 o_sclk = 1'b1;
            q = {q[18:0], i_serial_out_oe_n ? ~q[0] : i_serial_out};
            if (chain)
                o_serial_in = din[19-i];
            #80 o_sclk = 1'b0;
        end
    endtask
endmodule

// [tb/tb_sar_adc_serial_readout.sv]
// Testbench for the serial-readout converter control block
`timescale 1ns/1ps
module tb_sar_adc_serial_readout;
    import sarro_pkg::*;
    logic          i_clk;
    logic          i_resetn;
    logic          busy_en;
    logic          four_w;
    sarro_sample_t ana;
    wire           sclk, start, sin, sout, oe_n, conn, pd;
    int            errors, compares, cyc, tick;
    logic [19:0]   q;

    sarro_core DUT (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1),
        .i_sclk(sclk), .i_conversion_start_pin(start), .i_serial_in(sin),
        .o_serial_out(sout), .o_serial_out_oe_n(oe_n),
        .i_busy_indicator_en(busy_en), .i_four_wire(four_w),
        .i_analog(ana), .o_sample_connect(conn), .o_power_down(pd));
    sarro_host host (.i_clk(i_clk), .i_serial_out(sout),
        .i_serial_out_oe_n(oe_n), .o_sclk(sclk), .o_start(start),
        .o_serial_in(sin));

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic stop_test;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cut a hang short
    always @(posedge i_clk)
    begin
        tick++;
        if (tick > 20000)
        begin
            errors++;
            stop_test;
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    task automatic chk_word(input logic [19:0] got, input logic [19:0] exp,
                            input string m);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask

    function automatic logic [17:0] res_of(input sarro_sample_t a);
        logic [18:0] d;
        d = {1'b0, a.positive_analog_input} - {1'b0, a.negative_analog_input};
        return d[18:1];
    endfunction

    // Start, retrigger mid-run, change inputs, time the conversion
    task automatic convert(input logic lvl, input sarro_sample_t a);
        ana = a;
        host.set(1'b0, lvl);
        host.set(1'b1, lvl);
        cyc = 0;
        while (conn !== 1'b0 && cyc < 20)
        begin
            @(negedge i_clk);
            cyc++;
        end
        cyc = 0;
        chk_bit(oe_n, 1'b1, "output not released at start");
        ana = ~a;
        host.set(1'b0, lvl);
        host.set(1'b1, lvl);
        // Count from the start edge; the retrigger used two cycles
        cyc = 2;
        while (conn !== 1'b1 && cyc < 200)
        begin
            @(negedge i_clk);
            cyc++;
            if (cyc < CONV_CYC)
                chk_bit(conn, 1'b0, "inputs connected mid-run");
        end
        chk_word(20'(cyc), 20'(CONV_CYC), "conversion length");
        chk_bit(pd, 1'b1, "not powered down");
    endtask

    // Select, clock n bits, compare
    task automatic rd(input int n, input bit ch, input logic [19:0] exp);
        if (four_w)
            host.set(1'b1, 1'b0);
        else
            host.set(1'b0, sin);
        repeat (6) @(negedge i_clk);
        chk_bit(oe_n, 1'b0, "output not driven when selected");
        host.xfer(n, ch, 20'hda3c9, q);
        chk_word(q, exp, "read data");
        chk_bit(pd, 1'b1, "woke during readout");
    endtask

    task automatic t_three_wire;
        sarro_sample_t a;
        a = {18'h00005, 18'h3fffc};
        convert(1'b1, a);
        rd(18, 1'b0, {2'b00, res_of(a)});
    endtask

    task automatic t_four_wire_busy;
        sarro_sample_t a;
        a = {18'h3ffff, 18'h00000};
        four_w  = 1'b1;
        busy_en = 1'b1;
        convert(1'b1, a);
        rd(19, 1'b0, {1'b0, BUSY_BIT_VAL, res_of(a)});
        host.set(1'b1, 1'b1);
        repeat (6) @(negedge i_clk);
        chk_bit(oe_n, 1'b1, "output held after deselect");
        four_w  = 1'b0;
        busy_en = 1'b0;
    endtask

    task automatic t_daisy;
        sarro_sample_t a;
        a = {18'h12345, 18'h02346};
        convert(1'b0, a);
        // Pad bit, then the first chained bit from the serial input
        rd(20, 1'b1, {res_of(a), 2'b01});
    endtask

    initial
    begin
        errors   = 0;
        compares = 0;
        tick     = 0;
        busy_en  = 1'b0;
        four_w   = 1'b0;
        ana      = '0;
        i_resetn = 1'b0;
        // Longer than 4 cycles: link counter needs serial clock edges
        host.pulse(3);
        repeat (4) @(negedge i_clk);
        i_resetn = 1'b1;
        @(negedge i_clk);
        chk_bit(oe_n, 1'b1, "output driven after reset");
        chk_bit(conn, 1'b1, "inputs open after reset");
        // Link reset releases two serial clock edges late
        host.pulse(2);
        t_three_wire;
        t_four_wire_busy;
        t_daisy;
        stop_test;
    end
endmodule
